// ===== s3ct_pkg.sv
// Package of constants and types for the sinc3 conversion timing block.
package s3ct_pkg;

  // ==========================================================================
  // Clock and modulator timing
  localparam int unsigned MOD_CLKS        = 16;
  localparam int unsigned CNT_W           = 20;
  localparam int unsigned RATE_W          = 4;
  localparam int unsigned DELAY_W         = 3;
  localparam logic [DELAY_W-1:0] DELAY_RST = 3'h0;
  localparam logic [RATE_W-1:0]  RATE_RST  = 4'h0;
  localparam int unsigned DEFAULT_DELAY_MOD = 14;
  localparam int unsigned SETTLE_SKIP     = 2;
  localparam int unsigned SKIP_W          = 2;

  // ==========================================================================
  // Rate tables in modulator periods (steady period, sinc3 first, fast first)
  localparam int unsigned NRATES = 14;
  localparam int unsigned STEADY_TAB [NRATES] = '{
    102400, 51200, 25600, 15360, 12800, 5120, 4264,
    2560, 1280, 640, 320, 256, 128, 64};
  localparam int unsigned SINC_FIRST_TAB [NRATES] = '{
    307265, 153665, 76865, 46145, 38465, 15425, 12857,
    7745, 3905, 1985, 1025, 808, 424, 232};
  localparam int unsigned FAST_FIRST_TAB [NRATES] = '{
    104065, 52865, 27265, 15425, 14465, 5160, 4329,
    2600, 1320, 680, 360, 296, 168, 104};

  // Delay choices in modulator periods, index 0 is the default.
  localparam int unsigned DELAY_TAB [8] = '{
    DEFAULT_DELAY_MOD, 25, 64, 256, 1024, 2048, 4096, 1};

  typedef enum logic [2:0] {
    S3CT_IDLE,
    S3CT_DELAY,
    S3CT_FIRST,
    S3CT_STEADY
  } s3ct_state_type;

endpackage

// ===== s3ct_edge.sv
// Two-flop pin synchroniser with rising edge pulse.
`timescale 1ns/100ps
`default_nettype none
module s3ct_edge
  import s3ct_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Pin in, pulse out
  input  wire logic pin_i,
  output var  logic rise_o
);

  logic meta_r;
  logic sync_r;
  logic last_r;
  logic rise_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      last_r <= sync_r;
      rise_r <= sync_r & ~last_r;
    end
  end

  assign rise_o = rise_r;

endmodule
`default_nettype wire

// ===== s3ct_top.sv
// Conversion timing and settling control for the sinc3 filter path.
`timescale 1ns/100ps
`default_nettype none
module s3ct_top
  import s3ct_pkg::*;
#(
  parameter int unsigned MOD_DIV = MOD_CLKS
)
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  // Configuration
  input  wire logic               filter_select_i,
  input  wire logic [RATE_W-1:0]  rate_sel_i,
  input  wire logic [DELAY_W-1:0] conversion_delay_i,
  input  wire logic               continuous_i,
  // Start and stop sources
  input  wire logic               conversion_trigger_pin_i,
  input  wire logic               start_cmd_i,
  input  wire logic               stop_i,
  // Status
  output var  logic               sampling_o,
  output var  logic               sinc_path_o,
  output var  logic               busy_o,
  output var  logic               data_ready_o
);

  // ==========================================================================
  // Table lookups
  // Rate codes above the table act as the fastest rate.
  function automatic int unsigned rate_index(input logic [RATE_W-1:0] r);
    return (r < NRATES) ? int'(r) : NRATES - 1;
  endfunction

  function automatic logic [CNT_W-1:0] steady_len(input logic [RATE_W-1:0] r);
    int unsigned i;
    i = rate_index(r);
    return CNT_W'(STEADY_TAB[i]);
  endfunction

  function automatic logic [CNT_W-1:0] first_len(input logic [RATE_W-1:0] r,
                                                 input logic sinc);
    int unsigned i;
    i = rate_index(r);
    return sinc ? CNT_W'(SINC_FIRST_TAB[i]) : CNT_W'(FAST_FIRST_TAB[i]);
  endfunction

  function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c);
    return c - CNT_W'(1);
  endfunction

  // ==========================================================================
  // Start detection
  logic pin_rise;

  s3ct_edge u_edge (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .pin_i  (conversion_trigger_pin_i),
    .rise_o (pin_rise)
  );

  logic start;
  // Command strobe marks the seventh serial clock falling edge.
  assign start = pin_rise | start_cmd_i;

  // ==========================================================================
  // Modulator period tick, timing scales with clk_i.
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic       tick;

  always_comb begin
    div_nxt = div_r + 8'h01;
    if (start || div_r == 8'(MOD_DIV - 1)) begin
      div_nxt = 8'h00;
    end
  end

  assign tick = (div_r == 8'(MOD_DIV - 1));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ==========================================================================
  // Conversion sequencer
  s3ct_state_type   state_r;
  s3ct_state_type   state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [SKIP_W-1:0] skip_r;
  logic [SKIP_W-1:0] skip_nxt;
  logic             sinc_r;
  logic             sinc_nxt;
  logic             rdy_r;
  logic             rdy_nxt;
  logic             samp_r;
  logic             samp_nxt;
  logic             busy_r;
  logic             busy_nxt;
  logic             done;

  assign done = tick && (cnt_r == CNT_W'(1));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    skip_nxt  = skip_r;
    sinc_nxt  = sinc_r;
    rdy_nxt   = 1'b0;
    samp_nxt  = samp_r;
    if (start) begin
      // Filter bit zero selects sinc3.
      sinc_nxt  = ~filter_select_i;
      // Sinc3 loads a skip count of two, which nothing reads.
      skip_nxt  = filter_select_i ? '0 : SKIP_W'(SETTLE_SKIP);
      // Delay only ahead of the first conversion.
      cnt_nxt   = CNT_W'(DELAY_TAB[conversion_delay_i]);
      state_nxt = S3CT_DELAY;
      samp_nxt  = 1'b0;
    end else begin
      if (stop_i && state_r == S3CT_STEADY) begin
        state_nxt = S3CT_IDLE;
        samp_nxt  = 1'b0;
      end
      case (state_r)
        S3CT_IDLE: begin
          samp_nxt = 1'b0;
        end
        S3CT_DELAY: begin
          if (done) begin
            // First length covers sampling plus overhead.
            cnt_nxt   = sinc_r ? first_len(rate_sel_i, 1'b1)
                                 : first_len(rate_sel_i, 1'b0);
            state_nxt = S3CT_FIRST;
            samp_nxt  = 1'b1;
          end else if (tick) begin
            cnt_nxt = count_down(cnt_r);
          end
        end
        S3CT_FIRST, S3CT_STEADY: begin
          if (done) begin
            // Ready for every result; the skip count is not checked.
            rdy_nxt = 1'b1;
            if (continuous_i && !stop_i) begin
              // Steady period fixes rate and notch spacing.
              cnt_nxt   = steady_len(rate_sel_i);
              state_nxt = S3CT_STEADY;
            end else begin
              state_nxt = S3CT_IDLE;
              samp_nxt  = 1'b0;
            end
          end else if (tick) begin
            cnt_nxt = count_down(cnt_r);
          end
        end
        default: begin
          state_nxt = S3CT_IDLE;
          samp_nxt  = 1'b0;
        end
      endcase
    end
    // Busy follows the next state so that it leaves a flip-flop.
    busy_nxt = (state_nxt != S3CT_IDLE);
  end

  // ==========================================================================
  // Sequencer registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= S3CT_IDLE;
      cnt_r   <= '0;
      skip_r  <= '0;
      sinc_r  <= 1'b1;
      rdy_r   <= 1'b0;
      samp_r  <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      skip_r  <= skip_nxt;
      sinc_r  <= sinc_nxt;
      rdy_r   <= rdy_nxt;
      samp_r  <= samp_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign sampling_o   = samp_r;
  assign sinc_path_o  = sinc_r;
  assign busy_o       = busy_r;
  assign data_ready_o = rdy_r;

endmodule
`default_nettype wire

// ===== s3ct_properties.sv
// Checker of the conversion timing seen at the top ports.
`timescale 1ns/100ps
`default_nettype none
module s3ct_checker
  import s3ct_pkg::*;
#(
  parameter int unsigned MOD_DIV = 1
)
(
  // Clock, reset and inputs
  input wire logic               clk_i,
  input wire logic               nrst_i,
  input wire logic               filter_select_i,
  input wire logic [RATE_W-1:0]  rate_sel_i,
  input wire logic [DELAY_W-1:0] conversion_delay_i,
  input wire logic               continuous_i,
  input wire logic               conversion_trigger_pin_i,
  input wire logic               start_cmd_i,
  input wire logic               stop_i,
  // Outputs
  input wire logic               sampling_o,
  input wire logic               sinc_path_o,
  input wire logic               busy_o,
  input wire logic               data_ready_o
);
  localparam int G0 = 14*MOD_DIV-10, G1 = G0+4;
  localparam int S0 = 246*MOD_DIV-10, S1 = S0+4;
  localparam int F0 = 118*MOD_DIV-10, F1 = F0+4;
  localparam int P0 = 64*MOD_DIV-10, P1 = P0+4;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence quiet_s; !data_ready_o [*8]; endsequence
  sequence nosamp_s; !sampling_o [*8]; endsequence
  // ==========================================================================
  // Assertions
  ready_pulse_a:
    assert property (data_ready_o |=> !data_ready_o) else $error("long ready");
  delay_gap_a:
    assert property (start_cmd_i && conversion_delay_i == 3'h0 |=>
      nosamp_s ##[G0:G1] sampling_o) else $error("delay length");
  start_busy_a:
    assert property (start_cmd_i |=> busy_o) else $error("command start");
  pin_start_a:
    assert property ($rose(conversion_trigger_pin_i) |-> ##[3:6] busy_o)
    else $error("pin start");
  sinc_select_a:
    assert property (start_cmd_i |=> sinc_path_o == !$past(filter_select_i))
    else $error("filter choice");
  sinc_first_a:
    assert property (start_cmd_i && !filter_select_i && rate_sel_i == 4'hd
      && conversion_delay_i == 3'h0 |=> quiet_s ##[S0:S1] data_ready_o)
    else $error("sinc first length");
  fast_first_a:
    assert property (start_cmd_i && filter_select_i && rate_sel_i == 4'hd
      && conversion_delay_i == 3'h0 |=> quiet_s ##[F0:F1] data_ready_o)
    else $error("fast first length");
  steady_period_a:
    assert property (data_ready_o && continuous_i && rate_sel_i == 4'hd |=>
      quiet_s ##[P0:P1] data_ready_o) else $error("steady period");
endmodule
`default_nettype wire

// ===== s3ct_host.sv
// Host model that starts conversions by command or by trigger pin.
`timescale 1ns/100ps
`default_nettype none
module s3ct_host (
  // Clock
  input  wire logic clk_i,
  // Start sources
  output var  logic start_cmd_o,
  output var  logic trigger_pin_o
);
  initial begin
    start_cmd_o = 1'h0;
    trigger_pin_o = 1'h0;
  end
  // One pulse at the seventh serial clock edge of the command.
  task automatic cmd_start();
    @(posedge clk_i) start_cmd_o <= 1'h1;
    @(posedge clk_i) start_cmd_o <= 1'h0;
  endtask
  // Rising edge on the pin, held past the synchroniser.
  task automatic pin_start();
    @(posedge clk_i) trigger_pin_o <= 1'h1;
    repeat (4) @(posedge clk_i);
    trigger_pin_o <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== tb_sinc3_conversion_timing.sv
// Testbench of the sinc3 conversion timing block.
`timescale 1ns/100ps
`default_nettype none
module tb_sinc3_conversion_timing
  import s3ct_pkg::*;
;
  localparam int unsigned MOD_DIV = 1;
  localparam int T_SF = (DEFAULT_DELAY_MOD + SINC_FIRST_TAB[13]) * MOD_DIV;
  localparam int T_FF = (DEFAULT_DELAY_MOD + FAST_FIRST_TAB[13]) * MOD_DIV;
  localparam int T_ST = STEADY_TAB[13] * MOD_DIV;
  localparam int T_FC = (DEFAULT_DELAY_MOD + FAST_FIRST_TAB[12]) * MOD_DIV;
  logic               clk_i, nrst_i, fsel, cont, start, pin, busy, sinc, rdy;
  logic               stop, samp;
  logic [RATE_W-1:0]  rate;
  logic [DELAY_W-1:0] dly;
  int                 mismatches, n_compared, n;
  s3ct_host host (.clk_i(clk_i), .start_cmd_o(start), .trigger_pin_o(pin));
  s3ct_top #(.MOD_DIV(MOD_DIV)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .filter_select_i(fsel), .rate_sel_i(rate), .conversion_delay_i(dly),
    .continuous_i(cont), .conversion_trigger_pin_i(pin), .start_cmd_i(start),
    .stop_i(stop), .sampling_o(samp), .sinc_path_o(sinc), .busy_o(busy),
    .data_ready_o(rdy));
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      #1;
    end while (rdy !== 1'h1 && n < 3000);
  endtask
  function automatic logic in_win(input int e);
    return n >= e - 1 && n <= e + 2;
  endfunction
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_single(input logic f, input int e);
    fsel <= f;
    host.cmd_start();
    wait_ready();
    check(in_win(e), 1'h1);
    check(sinc, !f);
    check(samp, 1'h0);
    repeat (300) @(posedge clk_i);
    check(busy, 1'h0);
  endtask
  task automatic t_cont();
    fsel <= 1'h0;
    cont <= 1'h1;
    host.cmd_start();
    wait_ready();
    check(in_win(T_SF), 1'h1);
    repeat (2) begin
      wait_ready();
      check(in_win(T_ST), 1'h1);
      check(samp, 1'h1);
    end
    @(posedge clk_i) cont <= 1'h0;
    wait_ready();
    check(in_win(T_ST - 1), 1'h1);
    repeat (4) @(posedge clk_i);
    check(busy, 1'h0);
  endtask
  task automatic t_pin_restart();
    host.pin_start();
    #1;
    check(busy, 1'h1);
    wait_ready();
    check(in_win(T_SF), 1'h1);
    rate <= 4'hc;
    host.cmd_start();
    repeat (100) @(posedge clk_i);
    rate <= 4'hd;
    host.cmd_start();
    wait_ready();
    check(in_win(T_SF), 1'h1);
  endtask
  task automatic t_stop();
    {fsel, cont, rate} <= {1'h1, 1'h1, 4'hc};
    host.cmd_start();
    wait_ready();
    check(in_win(T_FC), 1'h1);
    @(posedge clk_i) stop <= 1'h1;
    @(posedge clk_i);
    stop <= 1'h0;
    {fsel, cont, rate} <= {1'h0, 1'h0, 4'hd};
    #1;
    check(busy, 1'h0);
    check(rdy, 1'h0);
  endtask
  initial begin
    mismatches = 0;
    n_compared = 0;
    nrst_i = 1'h0;
    {fsel, cont, dly, rate} = {1'h0, 1'h0, 3'h0, 4'hd};
    stop = 1'h0;
    repeat (4) @(posedge clk_i);
    check(busy, 1'h0);
    nrst_i <= 1'h1;
    t_single(1'h0, T_SF);
    $display("sinc single shot done");
    t_single(1'h1, T_FF);
    $display("low-latency single shot done");
    t_cont();
    $display("continuous done");
    t_stop();
    $display("stop in continuous done");
    t_pin_restart();
    $display("pin and restart done");
    complete_run();
  end
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
endmodule
bind s3ct_top s3ct_checker #(.MOD_DIV(MOD_DIV)) u_chk (.clk_i(clk_i),
  .nrst_i(nrst_i), .filter_select_i(filter_select_i),
  .rate_sel_i(rate_sel_i), .conversion_delay_i(conversion_delay_i),
  .continuous_i(continuous_i), .stop_i(stop_i),
  .conversion_trigger_pin_i(conversion_trigger_pin_i),
  .start_cmd_i(start_cmd_i), .sampling_o(sampling_o),
  .sinc_path_o(sinc_path_o), .busy_o(busy_o), .data_ready_o(data_ready_o));
`default_nettype wire
